// [core/ebert_top.sv]
// Implementation choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`include "ebert_map.svh"
module ebert_top
	import ebert_pkg::*;
(
	input wire logic pclk, // APB and framer clock, 50 MHz
	input wire logic presetn, // Asynchronous reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction, 1 writes
	input wire logic [7:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error on unmapped address
	input wire logic tx_bp_bit, // Transmit backplane data bit
	input wire logic tx_bp_valid, // Transmit backplane bit strobe
	input wire logic rx_line_bit, // Receive line data bit
	input wire logic rx_line_valid, // Receive line bit strobe
	output logic tx_line_bit, // Transmit data toward the line
	output logic tx_line_valid, // Strobe of tx_line_bit
	output logic rx_bp_bit, // Receive data toward the backplane
	output logic rx_bp_valid, // Strobe of rx_bp_bit
	output logic rx_framer_skip, // Receive framer bypassed
	output logic tx_framer_skip, // Transmit framer bypassed
	output logic irq // Level interrupt
);

	logic [7:0] ctrl;
	logic [7:0] next_ctrl;
	logic bert_switch;
	logic next_bert_switch;
	logic [1:0] int_enable;
	logic [1:0] next_int_enable;
	logic [1:0] int_status;
	logic [1:0] next_int_status;
	logic next_irq;
	logic [31:0] next_prdata;
	logic next_pready;
	logic next_pslverr;
	logic next_rx_framer_skip;
	logic next_tx_framer_skip;
	ebert_hist_t gen_hist;
	ebert_hist_t next_gen_hist;
	logic err_pend;
	logic next_err_pend;
	logic next_tx_line_bit;
	logic next_tx_line_valid;
	logic next_rx_bp_bit;
	logic next_rx_bp_valid;
	ebert_det_e det_state;
	ebert_det_e next_det_state;
	ebert_hist_t det_hist;
	ebert_hist_t next_det_hist;
	logic [5:0] run_cnt;
	logic [5:0] next_run_cnt;
	logic [2:0] err_cnt;
	logic [2:0] next_err_cnt;
	logic [5:0] win_cnt;
	logic [5:0] next_win_cnt;
	logic ev_gain;
	logic ev_loss;

	logic access;
	logic wr_en;
	logic setup;
	logic locked;
	logic gen_en;
	logic det_en;
	logic invert;
	ebert_kind_e kind;
	logic gen_tick;
	logic gen_fb;
	logic gen_quiet;
	logic gen_raw;
	logic gen_out;
	logic ins_rise;
	logic det_tick;
	logic det_bit;
	logic det_fb;
	logic det_match;

	function automatic logic addr_mapped(input logic [7:0] a);
		addr_mapped = (a == `EBERT_OFS_CTRL) || (a == `EBERT_OFS_LOOP_CTRL) ||
			(a == `EBERT_OFS_LOOP_TX) || (a == `EBERT_OFS_SWITCH) ||
			(a == `EBERT_OFS_INT_STATUS) || (a == `EBERT_OFS_INT_CLEAR) ||
			(a == `EBERT_OFS_INT_ENABLE);
	endfunction

	function automatic logic wr_hit(input logic en, input logic [7:0] a,
		input logic [7:0] ofs);
		wr_hit = en && (a == ofs);
	endfunction

	assign setup = psel && !penable;
	assign access = psel && penable && pready;
	assign wr_en = access && pwrite;
	assign locked = (det_state == EBERT_S_LOCK);
	assign gen_en = ctrl[`EBERT_B_GENERATE];
	assign det_en = ctrl[`EBERT_B_DETECT];
	assign invert = ctrl[`EBERT_B_INVERT];
	assign kind = ebert_kind_e'(ctrl[`EBERT_B_TYPE]);

	// APB slave: one access cycle, read data captured in the setup cycle
	always_comb begin
		next_pready = setup;
		next_pslverr = setup && !addr_mapped(paddr);
		next_prdata = 32'h0000_0000;
		if (setup && !pwrite) begin
			unique case (paddr)
				`EBERT_OFS_CTRL: begin
					next_prdata[7:0] = ctrl;
					next_prdata[`EBERT_B_LOCK] = locked;
				end
				`EBERT_OFS_SWITCH:
					next_prdata[`EBERT_B_SWITCH] = bert_switch;
				`EBERT_OFS_INT_STATUS: next_prdata[1:0] = int_status;
				`EBERT_OFS_INT_ENABLE: next_prdata[1:0] = int_enable;
				// Code registers have no function in this line mode
				default: next_prdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= next_pready;
			pslverr <= next_pslverr;
			prdata <= next_prdata;
		end
	end

	// Software registers
	always_comb begin
		next_ctrl = ctrl;
		next_bert_switch = bert_switch;
		next_int_enable = int_enable;
		if (wr_hit(wr_en, paddr, `EBERT_OFS_CTRL)) begin
			next_ctrl = pwdata[7:0];
			next_ctrl[`EBERT_B_LOCK] = 1'b0;
		end
		if (wr_hit(wr_en, paddr, `EBERT_OFS_SWITCH))
			next_bert_switch = pwdata[`EBERT_B_SWITCH];
		if (wr_hit(wr_en, paddr, `EBERT_OFS_INT_ENABLE))
			next_int_enable = pwdata[1:0];
		next_rx_framer_skip = next_ctrl[`EBERT_B_RX_SKIP];
		next_tx_framer_skip = next_ctrl[`EBERT_B_TX_SKIP];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= `EBERT_RST_CTRL;
			bert_switch <= `EBERT_RST_SWITCH;
			int_enable <= `EBERT_RST_INT;
			rx_framer_skip <= 1'b0;
			tx_framer_skip <= 1'b0;
		end else begin
			ctrl <= next_ctrl;
			bert_switch <= next_bert_switch;
			int_enable <= next_int_enable;
			rx_framer_skip <= next_rx_framer_skip;
			tx_framer_skip <= next_tx_framer_skip;
		end
	end

	// Generator steps on the strobe of the path it drives
	assign gen_tick = bert_switch ? rx_line_valid : tx_bp_valid;
	assign gen_raw = gen_fb | ((kind == EBERT_QRSS) & gen_quiet);
	assign gen_out = gen_raw ^ invert ^ err_pend;
	assign ins_rise = wr_hit(wr_en, paddr, `EBERT_OFS_CTRL) &&
		pwdata[`EBERT_B_INJECT] && !ctrl[`EBERT_B_INJECT];

	ebert_lfsr_tap u_gen_tap (
		.kind(kind),
		.hist(gen_hist),
		.fb(gen_fb),
		.quiet(gen_quiet)
	);

	always_comb begin
		next_gen_hist = gen_hist;
		if (!gen_en)
			next_gen_hist = `EBERT_SEED;
		else if (gen_tick)
			next_gen_hist = {gen_hist[18:0], gen_fb};
		// A pending flip survives until a bit carries it; new rise wins
		next_err_pend = gen_en && (ins_rise || (err_pend && !gen_tick));
		next_tx_line_valid = tx_bp_valid;
		next_tx_line_bit = tx_bp_bit;
		if (gen_en && !bert_switch)
			next_tx_line_bit = gen_out;
		next_rx_bp_valid = rx_line_valid;
		next_rx_bp_bit = rx_line_bit;
		if (gen_en && bert_switch)
			next_rx_bp_bit = gen_out;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gen_hist <= `EBERT_SEED;
			err_pend <= 1'b0;
			tx_line_bit <= 1'b0;
			tx_line_valid <= 1'b0;
			rx_bp_bit <= 1'b0;
			rx_bp_valid <= 1'b0;
		end else begin
			gen_hist <= next_gen_hist;
			err_pend <= next_err_pend;
			tx_line_bit <= next_tx_line_bit;
			tx_line_valid <= next_tx_line_valid;
			rx_bp_bit <= next_rx_bp_bit;
			rx_bp_valid <= next_rx_bp_valid;
		end
	end

	// Detector is self-synchronising on the received history. Limitation:
	// forced ones of the quasi signal count as errors, far below drop rate.
	assign det_tick = bert_switch ? tx_bp_valid : rx_line_valid;
	assign det_bit = (bert_switch ? tx_bp_bit : rx_line_bit) ^ invert;
	assign det_match = (det_bit == det_fb);

	ebert_lfsr_tap u_det_tap (
		.kind(kind),
		.hist(det_hist),
		.fb(det_fb),
		.quiet()
	);

	always_comb begin
		next_det_state = det_state;
		next_det_hist = det_hist;
		next_run_cnt = run_cnt;
		next_err_cnt = err_cnt;
		next_win_cnt = win_cnt;
		ev_gain = 1'b0;
		ev_loss = 1'b0;
		if (!det_en) begin
			next_det_state = EBERT_S_OFF;
			next_det_hist = 20'h00000;
			next_run_cnt = 6'h00;
			next_err_cnt = 3'h0;
			next_win_cnt = 6'h00;
		end else begin
			unique case (det_state)
				EBERT_S_OFF: next_det_state = EBERT_S_HUNT;
				EBERT_S_HUNT: if (det_tick) begin
					next_det_hist = {det_hist[18:0], det_bit};
					next_run_cnt = 6'h00;
					if (det_match && run_cnt == `EBERT_LOCK_LAST) begin
						next_det_state = EBERT_S_LOCK;
						ev_gain = 1'b1;
						next_err_cnt = 3'h0;
						next_win_cnt = 6'h00;
					end else if (det_match)
						next_run_cnt = run_cnt + 6'h01;
				end
				EBERT_S_LOCK: if (det_tick) begin
					next_det_hist = {det_hist[18:0], det_bit};
					next_win_cnt = win_cnt + 6'h01;
					if (!det_match && err_cnt == `EBERT_ERR_DROP_LAST) begin
						next_det_state = EBERT_S_HUNT;
						ev_loss = 1'b1;
						next_run_cnt = 6'h00;
					end else if (!det_match)
						next_err_cnt = err_cnt + 3'h1;
					else if (win_cnt == `EBERT_WIN_LAST)
						next_err_cnt = 3'h0;
				end
				default: next_det_state = EBERT_S_OFF;
			endcase
		end
		// Set wins over a clear in the same cycle
		next_int_status = int_status;
		if (wr_hit(wr_en, paddr, `EBERT_OFS_INT_CLEAR))
			next_int_status = int_status & ~pwdata[1:0];
		next_int_status[`EBERT_B_EV_GAIN] =
			next_int_status[`EBERT_B_EV_GAIN] | ev_gain;
		next_int_status[`EBERT_B_EV_LOSS] =
			next_int_status[`EBERT_B_EV_LOSS] | ev_loss;
		next_irq = |(next_int_status & next_int_enable);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			det_state <= EBERT_S_OFF;
			det_hist <= 20'h00000;
			run_cnt <= 6'h00;
			err_cnt <= 3'h0;
			win_cnt <= 6'h00;
			int_status <= `EBERT_RST_INT;
			irq <= 1'b0;
		end else begin
			det_state <= next_det_state;
			det_hist <= next_det_hist;
			run_cnt <= next_run_cnt;
			err_cnt <= next_err_cnt;
			win_cnt <= next_win_cnt;
			int_status <= next_int_status;
			irq <= next_irq;
		end
	end

	lock_flag_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		access && !pwrite && paddr == `EBERT_OFS_CTRL
		|-> prdata[`EBERT_B_LOCK] == $past(locked))
		else $error("lock flag read does not match detector state");

	line_gen_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		gen_en && !bert_switch && tx_bp_valid
		|=> tx_line_bit == $past(gen_out) && tx_line_valid)
		else $error("pattern not sent toward the line");

	bp_gen_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		gen_en && bert_switch && rx_line_valid
		|=> rx_bp_bit == $past(gen_out) && rx_bp_valid)
		else $error("pattern not sent toward the receive backplane");

	gen_idle_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		!gen_en |=> tx_line_bit == $past(tx_bp_bit) &&
			rx_bp_bit == $past(rx_line_bit))
		else $error("halted generator still alters data");

	route_switch_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		gen_en && bert_switch |=> tx_line_bit == $past(tx_bp_bit))
		else $error("switched generator touched the line path");

	det_off_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		!det_en ##1 !det_en |-> det_state == EBERT_S_OFF && run_cnt == 6'h00)
		else $error("detector active while disabled");

	lock_run_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		$rose(locked) |-> $past(run_cnt) == `EBERT_LOCK_LAST &&
			$past(det_tick) && $past(det_en))
		else $error("lock declared without full matching run");

	skip_write_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		wr_en && paddr == `EBERT_OFS_CTRL
		|=> rx_framer_skip == $past(pwdata[1]) &&
			tx_framer_skip == $past(pwdata[0]))
		else $error("bypass outputs do not follow the write");

	reserved_rd_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		access && !pwrite &&
		(paddr == `EBERT_OFS_LOOP_CTRL || paddr == `EBERT_OFS_LOOP_TX)
		|-> prdata == 32'h0000_0000)
		else $error("reserved code register read nonzero");

	inject_once_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		err_pend && gen_tick && !ins_rise |=> !err_pend)
		else $error("injected error not consumed by one bit");

endmodule // ebert_top

// [include/ebert_map.svh]
`ifndef EBERT_MAP_SVH
`define EBERT_MAP_SVH

// Register byte offsets on the APB window
`define EBERT_OFS_CTRL 8'h00
`define EBERT_OFS_LOOP_CTRL 8'h04
`define EBERT_OFS_LOOP_TX 8'h08
`define EBERT_OFS_SWITCH 8'h0c
`define EBERT_OFS_INT_STATUS 8'h10
`define EBERT_OFS_INT_CLEAR 8'h14
`define EBERT_OFS_INT_ENABLE 8'h18

// Field positions in bert_control_status_one
`define EBERT_B_TYPE 7
`define EBERT_B_INJECT 6
`define EBERT_B_INVERT 5
`define EBERT_B_LOCK 4
`define EBERT_B_DETECT 3
`define EBERT_B_GENERATE 2
`define EBERT_B_RX_SKIP 1
`define EBERT_B_TX_SKIP 0

// Field position in the switch register
`define EBERT_B_SWITCH 3

// Interrupt status bit positions
`define EBERT_B_EV_GAIN 0
`define EBERT_B_EV_LOSS 1

// Reset values
`define EBERT_RST_CTRL 8'h00
`define EBERT_RST_SWITCH 1'b0
`define EBERT_RST_INT 2'h0
`define EBERT_SEED 20'hfffff

// Detector thresholds: 32 matching bits to lock, 6 errors in 64 bits to drop
`define EBERT_LOCK_LAST 6'h1f
`define EBERT_ERR_DROP_LAST 3'h5
`define EBERT_WIN_LAST 6'h3f

`endif

// [include/ebert_pkg.sv]
package ebert_pkg;

	typedef enum logic {
		EBERT_PRBS15 = 1'b0,
		EBERT_QRSS = 1'b1
	} ebert_kind_e;

	typedef enum logic [1:0] {
		EBERT_S_OFF = 2'b00,
		EBERT_S_HUNT = 2'b01,
		EBERT_S_LOCK = 2'b10
	} ebert_det_e;

	typedef logic [19:0] ebert_hist_t;

endpackage

// [core/ebert_lfsr_tap.sv]
`timescale 1ns/1ps
// Feedback of the two test polynomials over a bit history, newest in bit 0
module ebert_lfsr_tap
	import ebert_pkg::*;
(
	input wire ebert_kind_e kind, // Pattern selected
	input wire ebert_hist_t hist, // Bit history
	output logic fb, // Next bit of the sequence
	output logic quiet // Long zero run, forces a one in the quasi signal
);

	always_comb begin
		unique case (kind)
			EBERT_PRBS15: fb = hist[14] ^ hist[13];
			EBERT_QRSS: fb = hist[19] ^ hist[16];
		endcase
		quiet = (hist[13:0] == 14'h0000);
	end

endmodule // ebert_lfsr_tap

// [verif/ebert_far_end.sv]
`timescale 1ns/1ps
// Line or backplane equipment sending a self-synchronising test stream
module ebert_far_end (
	input wire logic pclk, // Shared clock
	input wire logic presetn, // Reset, active low
	input wire logic run, // Send the test stream
	input wire logic corrupt, // Invert every sent bit
	input wire logic [1:0] gap, // Idle cycles between bits
	output logic bit_out, // Stream bit
	output logic valid_out // Stream strobe
);
	logic [14:0] lfsr;
	logic [1:0] idle;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lfsr <= 15'h7fff;
			idle <= 2'h0;
			bit_out <= 1'b0;
			valid_out <= 1'b0;
		end else if (run && idle >= gap) begin
			valid_out <= 1'b1;
			bit_out <= lfsr[14] ^ lfsr[13] ^ corrupt;
			lfsr <= {lfsr[13:0], lfsr[14] ^ lfsr[13]};
			idle <= 2'h0;
		end else begin
			// No strobe: never leave the last bit standing
			valid_out <= 1'b0;
			bit_out <= ~bit_out;
			idle <= idle + 2'h1;
		end
	end
endmodule // ebert_far_end

// [verif/e1_bert_control_and_framer_bypass_test.sv]
`timescale 1ns/1ps
`include "ebert_map.svh"
`define CHK(g, x) begin n_compared++; if ((g) !== (x)) begin num_errors++; \
$display("BAD t=%0t got=%h exp=%h", $time, g, x); end end
module e1_bert_control_and_framer_bypass_test;
	typedef struct {
		logic [7:0] a;
		logic w;
		logic [7:0] d;
		logic [7:0] r;
		logic e;
		logic [1:0] sk;
	} ebert_row_s;
	typedef struct {
		logic s;
		logic [7:0] c;
		logic ins;
	} ebert_gen_s;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, er;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic tx_bp_bit, tx_bp_valid, rx_line_bit, rx_line_valid;
	logic tx_line_bit, tx_line_valid, rx_bp_bit, rx_bp_valid;
	logic rx_framer_skip, tx_framer_skip;
	logic bp_run, bp_bad, ln_run, ln_bad, mon_on, sw, inv, qr, e;
	logic [19:0] h;
	int num_errors, n_compared, ndiff, nbits;
	ebert_row_s rows[16] = '{
		'{8'h00, 1'b0, 8'h00, 8'h00, 1'b0, 2'h0},
		'{8'h0c, 1'b0, 8'h00, 8'h00, 1'b0, 2'h0},
		'{8'h10, 1'b0, 8'h00, 8'h00, 1'b0, 2'h0},
		'{8'h00, 1'b1, 8'h83, 8'h00, 1'b0, 2'h3},
		'{8'h00, 1'b0, 8'h00, 8'h83, 1'b0, 2'h3},
		'{8'h00, 1'b1, 8'h11, 8'h00, 1'b0, 2'h1},
		'{8'h00, 1'b0, 8'h00, 8'h01, 1'b0, 2'h1},
		'{8'h00, 1'b1, 8'h02, 8'h00, 1'b0, 2'h2},
		'{8'h04, 1'b1, 8'hff, 8'h00, 1'b0, 2'h2},
		'{8'h04, 1'b0, 8'h00, 8'h00, 1'b0, 2'h2},
		'{8'h08, 1'b1, 8'hff, 8'h00, 1'b0, 2'h2},
		'{8'h08, 1'b0, 8'h00, 8'h00, 1'b0, 2'h2},
		'{8'h0c, 1'b1, 8'hff, 8'h00, 1'b0, 2'h2},
		'{8'h0c, 1'b0, 8'h00, 8'h08, 1'b0, 2'h2},
		'{8'h1c, 1'b1, 8'hff, 8'h00, 1'b1, 2'h2},
		'{8'h1c, 1'b0, 8'h00, 8'h00, 1'b1, 2'h2}};
	ebert_gen_s gens[7] = '{'{1'b0, 8'h04, 1'b0}, '{1'b0, 8'h24, 1'b0},
		'{1'b1, 8'h04, 1'b0}, '{1'b1, 8'h24, 1'b0}, '{1'b0, 8'h84, 1'b0},
		'{1'b0, 8'h04, 1'b1}, '{1'b1, 8'h04, 1'b1}};

	ebert_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.tx_bp_bit(tx_bp_bit), .tx_bp_valid(tx_bp_valid),
		.rx_line_bit(rx_line_bit), .rx_line_valid(rx_line_valid),
		.tx_line_bit(tx_line_bit), .tx_line_valid(tx_line_valid),
		.rx_bp_bit(rx_bp_bit), .rx_bp_valid(rx_bp_valid),
		.rx_framer_skip(rx_framer_skip), .tx_framer_skip(tx_framer_skip),
		.irq(irq));
	ebert_far_end u_bp (.pclk(pclk), .presetn(presetn), .run(bp_run),
		.corrupt(bp_bad), .gap(2'h1), .bit_out(tx_bp_bit),
		.valid_out(tx_bp_valid));
	ebert_far_end u_line (.pclk(pclk), .presetn(presetn), .run(ln_run),
		.corrupt(ln_bad), .gap(2'h0), .bit_out(rx_line_bit),
		.valid_out(rx_line_valid));

	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	// Reference generator, stepped on every strobe of the selected output
	always @(posedge pclk) begin
		if (mon_on && (sw ? rx_bp_valid : tx_line_valid) === 1'b1) begin
			e = qr ? h[19] ^ h[16] : h[14] ^ h[13];
			h = {h[18:0], e};
			if (qr && h[14:1] == 14'h0)
				e = 1'b1;
			nbits++;
			if ((sw ? rx_bp_bit : tx_line_bit) !== (e ^ inv))
				ndiff++;
		end
	end

	task automatic summarize;
		$display("compared %0d, mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic apb(input logic [7:0] a, input logic w,
		input logic [31:0] d);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1) begin
			num_errors++;
			summarize();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic wait_lock(input logic v);
		int n;
		n = 0;
		do begin
			apb(`EBERT_OFS_CTRL, 1'b0, 32'h0);
			n++;
		end while (rd[4] !== v && n < 60);
		if (rd[4] !== v) begin
			num_errors++;
			summarize();
		end
	endtask

	// Streams stop while reconfiguring so the reference starts at the seed
	task automatic gen_case(input ebert_gen_s g);
		bp_run <= 1'b0;
		ln_run <= 1'b0;
		apb(`EBERT_OFS_CTRL, 1'b1, 32'h0);
		apb(`EBERT_OFS_SWITCH, 1'b1, {28'h0, g.s, 3'h0});
		apb(`EBERT_OFS_CTRL, 1'b1, {24'h0, g.c});
		sw = g.s;
		inv = g.c[5];
		qr = g.c[7];
		h = 20'hfffff;
		ndiff = 0;
		nbits = 0;
		mon_on = 1'b1;
		bp_run <= ~g.s;
		ln_run <= g.s;
		repeat (30) @(posedge pclk);
		if (g.ins)
			apb(`EBERT_OFS_CTRL, 1'b1, {24'h0, g.c | 8'h40});
		repeat (60) @(posedge pclk);
		bp_run <= 1'b0;
		ln_run <= 1'b0;
		repeat (3) @(posedge pclk);
		mon_on = 1'b0;
	endtask

	initial begin
		{presetn, psel, penable, pwrite, bp_run, bp_bad, ln_run} = 7'h0;
		{ln_bad, mon_on, sw, inv, qr} = 5'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		h = 20'hfffff;
		repeat (2) @(posedge pclk);
		`CHK({pready, pslverr, irq, tx_line_valid, rx_bp_valid}, 5'h0)
		presetn <= 1'b1;
		@(posedge pclk);
		foreach (rows[i]) begin
			apb(rows[i].a, rows[i].w, {24'h0, rows[i].d});
			@(posedge pclk);
			`CHK(er, rows[i].e)
			if (!rows[i].w)
				`CHK(rd, {24'h0, rows[i].r})
			`CHK({rx_framer_skip, tx_framer_skip}, rows[i].sk)
		end
		foreach (gens[i]) begin
			gen_case(gens[i]);
			`CHK(ndiff, int'(gens[i].ins))
			`CHK(nbits > 40, 1'b1)
		end
		apb(`EBERT_OFS_CTRL, 1'b1, 32'h0);
		apb(`EBERT_OFS_SWITCH, 1'b1, 32'h0);
		apb(`EBERT_OFS_INT_ENABLE, 1'b1, 32'h1);
		ln_run <= 1'b1;
		repeat (80) @(posedge pclk);
		// Generator off: the receive path is a plain one-cycle copy
		e = rx_line_bit;
		@(posedge pclk);
		`CHK({rx_bp_bit, rx_bp_valid}, {e, 1'b1})
		apb(`EBERT_OFS_CTRL, 1'b0, 32'h0);
		`CHK(rd[4], 1'b0)
		apb(`EBERT_OFS_CTRL, 1'b1, 32'h8);
		wait_lock(1'b1);
		// Fresh read: lock must hold, not just have flickered once
		apb(`EBERT_OFS_CTRL, 1'b0, 32'h0);
		`CHK(rd[4], 1'b1)
		`CHK(irq, 1'b1)
		apb(`EBERT_OFS_INT_STATUS, 1'b0, 32'h0);
		`CHK(rd[1:0], 2'h1)
		apb(`EBERT_OFS_INT_CLEAR, 1'b1, 32'h1);
		apb(`EBERT_OFS_INT_STATUS, 1'b0, 32'h0);
		`CHK(rd[1:0], 2'h0)
		`CHK(irq, 1'b0)
		ln_bad <= 1'b1;
		wait_lock(1'b0);
		apb(`EBERT_OFS_CTRL, 1'b0, 32'h0);
		`CHK(rd[4], 1'b0)
		`CHK(irq, 1'b0)
		apb(`EBERT_OFS_INT_ENABLE, 1'b1, 32'h3);
		repeat (2) @(posedge pclk);
		`CHK(irq, 1'b1)
		apb(`EBERT_OFS_INT_CLEAR, 1'b1, 32'h3);
		apb(`EBERT_OFS_CTRL, 1'b1, 32'h28);
		wait_lock(1'b1);
		apb(`EBERT_OFS_CTRL, 1'b0, 32'h0);
		`CHK(rd[4], 1'b1)
		apb(`EBERT_OFS_CTRL, 1'b1, 32'h0);
		apb(`EBERT_OFS_CTRL, 1'b0, 32'h0);
		`CHK(rd[4], 1'b0)
		// Line stays corrupt: lock can only come from the backplane
		apb(`EBERT_OFS_SWITCH, 1'b1, 32'h8);
		bp_run <= 1'b1;
		apb(`EBERT_OFS_CTRL, 1'b1, 32'h0b);
		wait_lock(1'b1);
		apb(`EBERT_OFS_CTRL, 1'b0, 32'h0);
		`CHK(rd[4], 1'b1)
		// Generator off: the transmit path is a plain one-cycle copy
		e = tx_bp_bit;
		@(posedge pclk);
		`CHK(tx_line_bit, e)
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		`CHK({rx_framer_skip, tx_framer_skip, irq}, 3'h0)
		presetn <= 1'b1;
		@(posedge pclk);
		apb(`EBERT_OFS_CTRL, 1'b0, 32'h0);
		`CHK(rd, 32'h0)
		summarize();
	end
endmodule // e1_bert_control_and_framer_bypass_test
